/* File: src/osp_ctrl.v */
// output align and loop phase offset control, top level
//
// Operation
// - automute holds outputs, synchronous start on lock
// - group dividers leave reset on one cycle
// - join group: divider, post-divider, global enables
// - pulse divider aligned only with divider enable
// - request from pin function 31 or software
// - aligned dividers held in reset, output low
// - release restarts common-source outputs phase aligned
// - channels without align enable keep running unless their source post-divider is held
// - selected post-divider reset, its outputs invalid
// - unselected post-dividers keep running during event
// - divide-by-one bypass skips channel hold, output low while its post-divider is held
// - pin polarity and software bit set level
// - zero delay feeds first output back internally
// - 45-bit signed phase offset, reset zero
// - one offset serves whole loop domain
// - offset, gain and exponent at fixed registers
// - without automute outputs may run unstable
`timescale 1ns/1ps
`include "osp_ctrl_map.vh"
module osp_ctrl #(
  parameter NCH  = 4,
  parameter NPLL = 2,
  parameter SELW = 1,
  parameter RW   = 8
) (
  // clock and reset
  input  wire               mclk_i,
  input  wire               arst_n_i,
  // register port
  input  wire [9:0]         reg_addr_i,
  input  wire [7:0]         reg_wdata_i,
  input  wire               reg_wr_i,
  input  wire               reg_rd_i,
  output reg  [7:0]         reg_rdata_o,
  // align request pin
  input  wire               gpio_i,
  input  wire [5:0]         pin_function_select_i,
  input  wire               pin_polarity_invert_i,
  // group configuration
  input  wire               align_global_enable_i,
  input  wire [NPLL-1:0]    post_divider_align_enable_i,
  input  wire [NPLL*RW-1:0] post_divider_ratio_i,
  input  wire [NCH-1:0]     ch_div_align_enable_i,
  input  wire [NCH-1:0]     pulse_divider_align_enable_i,
  input  wire [NCH*SELW-1:0] ch_pll_select_i,
  input  wire [NCH*RW-1:0]  ch_ratio_i,
  input  wire [NCH-1:0]     ch_bypass_i,
  input  wire [NCH-1:0]     ch_auto_mute_enable_i,
  // lock and feedback
  input  wire               apll_lock_i,
  input  wire               zero_delay_feedback_mode_i,
  input  wire               ext_feedback_i,
  // channel outputs
  output wire [NCH-1:0]     clk_out_o,
  output reg  [NCH-1:0]     ch_valid_o,
  output reg  [NCH-1:0]     pulse_div_reset_o,
  output reg  [NPLL-1:0]    post_div_reset_o,
  output reg                align_active_o,
  output reg                feedback_clk_o,
  // loop parameters towards the time_to_digital_converter
  output reg  [44:0]        loop_phase_offset_o,
  output wire [15:0]        loop_gain_multiplier_o,
  output wire [7:0]         loop_gain_count_o,
  output wire [7:0]         loop_decimation_exponent_o
);

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  reg [2:0] meta_r;
  reg [2:0] sync_r;

  // the first stage is read by the second stage only
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
    end else begin
      meta_r <= {ext_feedback_i, apll_lock_i, gpio_i};
      sync_r <= meta_r;
    end
  end

  wire gpio_s_w = sync_r[0];
  wire lock_s_w = sync_r[1];
  wire fb_s_w   = sync_r[2];

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  reg        sw_req_r;
  reg [7:0]  gain_b_hi_r;
  reg [7:0]  gain_b_lo_r;
  reg [7:0]  gain_c_r;
  reg [7:0]  decim_a_r;
  reg [4:0]  ofs5_r;
  reg [7:0]  ofs4_r;
  reg [7:0]  ofs3_r;
  reg [7:0]  ofs2_r;
  reg [7:0]  ofs1_r;
  reg [7:0]  ofs0_r;
  reg [7:0]  rd_nxt;

  wire wr_w = reg_wr_i;

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sw_req_r    <= 1'b0;
      gain_b_hi_r <= `OSP_BYTE_RESET;
      gain_b_lo_r <= `OSP_BYTE_RESET;
      gain_c_r    <= `OSP_BYTE_RESET;
      decim_a_r   <= `OSP_BYTE_RESET;
      ofs5_r      <= 5'h00;
      ofs4_r      <= `OSP_BYTE_RESET;
      ofs3_r      <= `OSP_BYTE_RESET;
      ofs2_r      <= `OSP_BYTE_RESET;
      ofs1_r      <= `OSP_BYTE_RESET;
      ofs0_r      <= `OSP_BYTE_RESET;
    end else if (wr_w) begin
      case (reg_addr_i)
        `OSP_ADDR_SYNC_CONTROL: begin
          sw_req_r <= reg_wdata_i[`OSP_SOFTWARE_ALIGN_REQUEST_BIT];
        end
        `OSP_ADDR_GAIN_B_HIGH: begin
          gain_b_hi_r <= reg_wdata_i;
        end
        `OSP_ADDR_GAIN_B_LOW: begin
          gain_b_lo_r <= reg_wdata_i;
        end
        `OSP_ADDR_PH_OFS_BYTE5: begin
          ofs5_r <= reg_wdata_i[`OSP_PH_OFS_TOP_BITS-1:0];
        end
        `OSP_ADDR_PH_OFS_BYTE4: begin
          ofs4_r <= reg_wdata_i;
        end
        `OSP_ADDR_PH_OFS_BYTE3: begin
          ofs3_r <= reg_wdata_i;
        end
        `OSP_ADDR_PH_OFS_BYTE2: begin
          ofs2_r <= reg_wdata_i;
        end
        `OSP_ADDR_PH_OFS_BYTE1: begin
          ofs1_r <= reg_wdata_i;
        end
        `OSP_ADDR_PH_OFS_BYTE0: begin
          ofs0_r <= reg_wdata_i;
        end
        `OSP_ADDR_GAIN_C: begin
          gain_c_r <= reg_wdata_i;
        end
        `OSP_ADDR_DECIM_A: begin
          decim_a_r <= reg_wdata_i;
        end
        default: begin
          sw_req_r <= sw_req_r;
        end
      endcase
    end
  end

  // the offset is handed to the loop only when the low byte lands, so a
  // multi-byte update never reaches the detector half written
  wire [44:0] ofs_new_w = {ofs5_r, ofs4_r, ofs3_r, ofs2_r, ofs1_r,
                           reg_wdata_i};

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      loop_phase_offset_o <= `OSP_PH_OFS_RESET;
    end else if (wr_w && reg_addr_i == `OSP_ADDR_PH_OFS_BYTE0) begin
      loop_phase_offset_o <= ofs_new_w;
    end
  end

  assign loop_gain_multiplier_o     = {gain_b_hi_r, gain_b_lo_r};
  assign loop_gain_count_o          = gain_c_r;
  // a stored zero stands for 32; software does the substitution
  assign loop_decimation_exponent_o = decim_a_r;

  // ---------------------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------------------
  always @* begin
    rd_nxt = 8'h00;
    case (reg_addr_i)
      `OSP_ADDR_SYNC_CONTROL: begin
        rd_nxt[`OSP_SOFTWARE_ALIGN_REQUEST_BIT]     = sw_req_r;
        rd_nxt[`OSP_SYNC_ACTIVE_BIT] = align_active_o;
        rd_nxt[`OSP_SYNC_LOCK_BIT]   = lock_s_w;
      end
      `OSP_ADDR_GAIN_B_HIGH:  rd_nxt = gain_b_hi_r;
      `OSP_ADDR_GAIN_B_LOW:   rd_nxt = gain_b_lo_r;
      `OSP_ADDR_PH_OFS_BYTE5: rd_nxt = {3'h0, ofs5_r};
      `OSP_ADDR_PH_OFS_BYTE4: rd_nxt = ofs4_r;
      `OSP_ADDR_PH_OFS_BYTE3: rd_nxt = ofs3_r;
      `OSP_ADDR_PH_OFS_BYTE2: rd_nxt = ofs2_r;
      `OSP_ADDR_PH_OFS_BYTE1: rd_nxt = ofs1_r;
      `OSP_ADDR_PH_OFS_BYTE0: rd_nxt = ofs0_r;
      `OSP_ADDR_GAIN_C:       rd_nxt = gain_c_r;
      `OSP_ADDR_DECIM_A:      rd_nxt = decim_a_r;
      default:                rd_nxt = 8'h00;
    endcase
  end

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // align request
  // ---------------------------------------------------------------------------
  wire pin_sel_w = (pin_function_select_i == `OSP_PIN_FUNC_ALIGN);
  wire pin_act_w = pin_sel_w & (gpio_s_w ^ pin_polarity_invert_i);
  wire req_w     = pin_act_w | sw_req_r;

  // one registered level feeds every divider, so release lands on one cycle
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      align_active_o <= 1'b0;
    end else begin
      align_active_o <= req_w & align_global_enable_i;
    end
  end

  // ---------------------------------------------------------------------------
  // post-dividers
  // ---------------------------------------------------------------------------
  wire [NPLL-1:0] pd_tick_w;
  wire [NPLL-1:0] pd_hold_w;
  reg  [NPLL-1:0] pd_clk_r;

  genvar p;
  generate
    for (p = 0; p < NPLL; p = p + 1) begin : g_pd
      reg  [RW-1:0] cnt_r;
      wire [RW-1:0] ratio_w = post_divider_ratio_i[p*RW +: RW];

      // unselected post-dividers run through the event
      assign pd_hold_w[p] = align_active_o &
                            post_divider_align_enable_i[p];
      assign pd_tick_w[p] = ~pd_hold_w[p] &
                            (cnt_r >= ratio_w - {{(RW-1){1'b0}}, 1'b1});

      always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          cnt_r       <= {RW{1'b0}};
          pd_clk_r[p] <= 1'b0;
        end else if (pd_hold_w[p]) begin
          cnt_r       <= {RW{1'b0}};
          pd_clk_r[p] <= 1'b0;
        end else if (pd_tick_w[p]) begin
          cnt_r       <= {RW{1'b0}};
          pd_clk_r[p] <= ~pd_clk_r[p];
        end else begin
          cnt_r <= cnt_r + {{(RW-1){1'b0}}, 1'b1};
        end
      end
    end
  endgenerate

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      post_div_reset_o <= {NPLL{1'b0}};
    end else begin
      post_div_reset_o <= pd_hold_w;
    end
  end

  // ---------------------------------------------------------------------------
  // output channels
  // ---------------------------------------------------------------------------
  wire [NCH-1:0] ch_hold_w;
  wire [NCH-1:0] ch_mute_w;
  wire [NCH-1:0] ch_src_hold_w;

  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_ch
      wire [SELW-1:0] sel_w = ch_pll_select_i[c*SELW +: SELW];
      wire            in_grp_w;

      // auto-mute keeps the output quiet until lock; without it the output
      // follows the divider even while the loop is still settling
      assign ch_mute_w[c] = ch_auto_mute_enable_i[c] & ~lock_s_w;
      // a channel only joins when its source post-divider is aligned too;
      // group membership therefore also requires the align enable of the channel's selected post-divider
      assign in_grp_w = ch_div_align_enable_i[c] &
                        post_divider_align_enable_i[sel_w];
      assign ch_hold_w[c] = ch_mute_w[c] |
                            (align_active_o & in_grp_w);
      assign ch_src_hold_w[c] = pd_hold_w[sel_w];

      osp_div #(
        .RW (RW)
      ) u_div (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .tick_i   (pd_tick_w[sel_w]),
        .pd_clk_i (pd_clk_r[sel_w]),
        .hold_i   (ch_hold_w[c]),
        .mute_i   (ch_mute_w[c]),
        .bypass_i (ch_bypass_i[c]),
        .ratio_i  (ch_ratio_i[c*RW +: RW]),
        .clk_o    (clk_out_o[c])
      );

      always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          ch_valid_o[c]        <= 1'b0;
          pulse_div_reset_o[c] <= 1'b0;
        end else begin
          ch_valid_o[c] <= ~ch_src_hold_w[c] & ~ch_mute_w[c];
          pulse_div_reset_o[c] <= align_active_o & in_grp_w &
                                  pulse_divider_align_enable_i[c];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // zero delay feedback
  // ---------------------------------------------------------------------------
  // the external path is kept for non zero-delay use
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      feedback_clk_o <= 1'b0;
    end else begin
      feedback_clk_o <= zero_delay_feedback_mode_i ? clk_out_o[0] :
                        fb_s_w;
    end
  end

endmodule // osp_ctrl

/* File: src/osp_ctrl_map.vh */
// register offsets, field positions, reset values and codes of the output align block
`ifndef OSP_CTRL_MAP_VH
`define OSP_CTRL_MAP_VH

// ----------------------------------------------------------------------------
// register offsets on the register port
// ----------------------------------------------------------------------------
`define OSP_ADDR_SYNC_CONTROL   10'h015
`define OSP_ADDR_GAIN_B_HIGH    10'h224
`define OSP_ADDR_GAIN_B_LOW     10'h225
`define OSP_ADDR_PH_OFS_BYTE5   10'h226
`define OSP_ADDR_PH_OFS_BYTE4   10'h227
`define OSP_ADDR_PH_OFS_BYTE3   10'h228
`define OSP_ADDR_PH_OFS_BYTE2   10'h229
`define OSP_ADDR_PH_OFS_BYTE1   10'h22a
`define OSP_ADDR_PH_OFS_BYTE0   10'h22b
`define OSP_ADDR_GAIN_C         10'h236
`define OSP_ADDR_DECIM_A        10'h237

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define OSP_SOFTWARE_ALIGN_REQUEST_BIT         6
`define OSP_SYNC_ACTIVE_BIT     0
`define OSP_SYNC_LOCK_BIT       1
`define OSP_PH_OFS_TOP_BITS     5

// ----------------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------------
`define OSP_BYTE_RESET          8'h00
`define OSP_PH_OFS_RESET        45'h0000_0000_0000
`define OSP_PIN_FUNC_ALIGN      6'h1f

`endif

/* File: src/osp_div.v */
// one output channel divider with align reset, bypass and mute
`timescale 1ns/1ps
module osp_div #(
  parameter RW = 8
) (
  // clock and reset
  input  wire          mclk_i,
  input  wire          arst_n_i,
  // source post-divider
  input  wire          tick_i,
  input  wire          pd_clk_i,
  // control
  input  wire          hold_i,
  input  wire          mute_i,
  input  wire          bypass_i,
  input  wire [RW-1:0] ratio_i,
  // output
  output reg           clk_o
);

  reg  [RW-1:0] cnt_r;
  wire [RW-1:0] half_w;
  wire          wrap_w;

  assign half_w = ratio_i >> 1;
  assign wrap_w = (cnt_r >= ratio_i - {{(RW-1){1'b0}}, 1'b1});

  // ---------------------------------------------------------------------------
  // count post-divider ticks; every divider leaves hold at count zero, so all
  // dividers on one source post-divider released on one cycle see their first rising edge together
  // ---------------------------------------------------------------------------
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= {RW{1'b0}};
      clk_o <= 1'b0;
    end else if (bypass_i) begin
      cnt_r <= {RW{1'b0}};
      clk_o <= mute_i ? 1'b0 : pd_clk_i;
    end else if (hold_i) begin
      cnt_r <= {RW{1'b0}};
      clk_o <= 1'b0;
    end else if (tick_i) begin
      cnt_r <= wrap_w ? {RW{1'b0}} : cnt_r + {{(RW-1){1'b0}}, 1'b1};
      clk_o <= mute_i ? 1'b0 : (cnt_r < half_w);
    end
  end

endmodule // osp_div

/* File: verification/osp_ctrl_bench.sv */
// self-checking bench of the output align and phase offset block
`timescale 1ns/1ps
`include "osp_ctrl_map.vh"
module osp_ctrl_bench;
  localparam NCH = 4;
  localparam NPLL = 2;
  localparam SELW = 1;
  localparam RW = 8;
  localparam [15:0] GB = 16'h0248;
  localparam [7:0] GC = 8'h07;
  localparam [7:0] GA = 8'h00;
  localparam longint FVCO_MHZ = 2500;
  reg         mclk_i = 1'b0;
  reg         arst_n_i = 1'b0;
  reg  [9:0]  reg_addr_i = 10'h000;
  reg  [7:0]  reg_wdata_i = 8'h00;
  reg         reg_wr_i = 1'b0;
  reg         reg_rd_i = 1'b0;
  reg         gpio_i = 1'b0;
  reg  [5:0]  pin_function_select_i = 6'h00;
  reg         pin_polarity_invert_i = 1'b0;
  reg         align_global_enable_i = 1'b0;
  reg  [1:0]  post_divider_align_enable_i = 2'b01;
  reg  [15:0] post_divider_ratio_i = 16'h0202;
  reg  [3:0]  ch_div_align_enable_i = 4'b1011;
  reg  [3:0]  pulse_divider_align_enable_i = 4'b0110;
  reg  [3:0]  ch_pll_select_i = 4'b1100;
  reg  [31:0] ch_ratio_i = 32'h0404_0604;
  reg  [3:0]  ch_bypass_i = 4'b1000;
  reg  [3:0]  ch_auto_mute_enable_i = 4'h0;
  reg         apll_lock_i = 1'b1;
  reg         zero_delay_feedback_mode_i = 1'b0;
  reg         ext_feedback_i = 1'b0;
  wire [7:0]  reg_rdata_o, loop_gain_count_o, loop_decimation_exponent_o;
  wire [3:0]  clk_out_o, ch_valid_o, pulse_div_reset_o;
  wire [1:0]  post_div_reset_o;
  wire        align_active_o, feedback_clk_o;
  wire [44:0] loop_phase_offset_o;
  wire [15:0] loop_gain_multiplier_o;
  int         rises [NCH];
  int         start [NCH];
  int         miscompares = 0;
  int         n_compared = 0;
  int         r0, r1, r2, r3, old;
  reg  [15:0] lfsr = 16'h34c1;
  reg  [7:0]  mem [10];
  reg  [47:0] v;
  osp_ctrl #(.NCH(NCH), .NPLL(NPLL), .SELW(SELW), .RW(RW)) u_osp_ctrl (
    .mclk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .gpio_i, .pin_function_select_i, .pin_polarity_invert_i,
    .align_global_enable_i, .post_divider_align_enable_i,
    .post_divider_ratio_i, .ch_div_align_enable_i,
    .pulse_divider_align_enable_i, .ch_pll_select_i, .ch_ratio_i,
    .ch_bypass_i, .ch_auto_mute_enable_i, .apll_lock_i,
    .zero_delay_feedback_mode_i, .ext_feedback_i, .clk_out_o, .ch_valid_o,
    .pulse_div_reset_o, .post_div_reset_o, .align_active_o, .feedback_clk_o,
    .loop_phase_offset_o, .loop_gain_multiplier_o, .loop_gain_count_o,
    .loop_decimation_exponent_o);
  osp_ctrl_partner #(.NCH(NCH)) u_osp_ctrl_partner (.mclk_i(mclk_i),
    .arst_n_i(arst_n_i), .clk_i(clk_out_o), .rises_o(rises), .start_o(start));
  // ----
  // helpers
  // ----
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) ext_feedback_i <= ~ext_feedback_i;
  function [15:0] nxt(input [15:0] s);
    nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [9:0] adr(input int k);
    adr = k < 8 ? `OSP_ADDR_GAIN_B_HIGH + 10'(k) : `OSP_ADDR_GAIN_C + 10'(k - 8);
  endfunction
  function [47:0] ofs(input longint t_ps);
    longint sc;
    sc = GB * (GC + 1) * (longint'(1) << (32 - (GA == 0 ? 32 : GA)));
    ofs = 48'(2 * t_ps * FVCO_MHZ * sc / 1000000);
  endfunction
  task chk(input string nm, input [47:0] seen, input [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task wr(input [9:0] a, input [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input [9:0] a, input [7:0] exp);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("read data", reg_rdata_o, exp);
  endtask
  task wofs(input [47:0] x);
    for (int j = 5; j >= 0; j--)
      wr(`OSP_ADDR_PH_OFS_BYTE5 + 10'(5 - j), x[j*8 +: 8]);
    step(1);
    chk("phase offset", loop_phase_offset_o, x[44:0]);
  endtask
  task final_report;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk_i);
    miscompares++;
    final_report;
  end
  // ----
  // scenarios
  // ----
  initial begin
    step(20);
    arst_n_i <= 1'b1;
    step(1);
    for (int k = 0; k < 10; k++)
      rd(adr(k), 8'h00);
    for (int k = 0; k < 10; k++) begin
      lfsr = nxt(lfsr);
      mem[k] = k == 2 ? lfsr[7:0] & 8'h1f : lfsr[7:0];
      wr(adr(k), lfsr[7:0]);
    end
    for (int k = 0; k < 10; k++)
      rd(adr(k), mem[k]);
    chk("offset", loop_phase_offset_o, {mem[2][4:0], mem[3], mem[4], mem[5],
      mem[6], mem[7]});
    rd(10'h3ff, 8'h00);
    wr(`OSP_ADDR_SYNC_CONTROL, 8'hff);
    rd(`OSP_ADDR_SYNC_CONTROL, 8'h42);
    chk("no global enable", align_active_o, 0);
    wr(`OSP_ADDR_SYNC_CONTROL, 8'h00);
    wr(`OSP_ADDR_GAIN_B_HIGH, GB[15:8]);
    wr(`OSP_ADDR_GAIN_B_LOW, GB[7:0]);
    wr(`OSP_ADDR_GAIN_C, GC);
    wr(`OSP_ADDR_DECIM_A, GA);
    step(1);
    chk("gain b", loop_gain_multiplier_o, GB);
    chk("gain c", loop_gain_count_o, GC);
    chk("decimation a", loop_decimation_exponent_o, GA);
    // external path lags the toggling pin by three odd edges: inverse level
    chk("ext feedback", feedback_clk_o, !ext_feedback_i);
    wofs(ofs(1000));
    wofs(ofs(40000 - 1000));
    for (int r = 0; r < 2; r++) begin
      lfsr = nxt(lfsr);
      v[47:32] = lfsr;
      lfsr = nxt(lfsr);
      v[31:16] = lfsr;
      lfsr = nxt(lfsr);
      v[15:0] = lfsr;
      wofs({3'b000, v[44:0]});
    end
    zero_delay_feedback_mode_i <= 1'b1;
    align_global_enable_i <= 1'b1;
    wr(`OSP_ADDR_SYNC_CONTROL, 8'h40);
    step(3);
    r0 = rises[0];
    r1 = rises[1];
    r2 = rises[2];
    r3 = rises[3];
    step(20);
    chk("held ch0", rises[0], r0);
    chk("held ch1", rises[1], r1);
    chk("free ch2", rises[2] > r2, 1);
    chk("bypass ch3", rises[3] > r3, 1);
    chk("post reset", post_div_reset_o, 2'b01);
    chk("pulse reset", pulse_div_reset_o, 4'b0010);
    chk("valid", ch_valid_o, 4'b1100);
    old = start[0];
    wr(`OSP_ADDR_SYNC_CONTROL, 8'h00);
    step(40);
    chk("restart", start[0] != old, 1);
    chk("aligned start", start[1], start[0]);
    pin_function_select_i <= `OSP_PIN_FUNC_ALIGN;
    for (int p = 0; p < 2; p++) begin
      pin_polarity_invert_i <= p[0];
      gpio_i <= p[0];
      step(6);
      chk("pin idle", align_active_o, 0);
      gpio_i <= !p[0];
      step(6);
      chk("pin request", align_active_o, 1);
    end
    pin_function_select_i <= 6'h1e;
    step(6);
    chk("other function", align_active_o, 0);
    ch_auto_mute_enable_i <= 4'b0011;
    apll_lock_i <= 1'b0;
    step(8);
    chk("muted", {clk_out_o[1:0], ch_valid_o[1:0]}, 0);
    r2 = rises[2];
    old = start[0];
    step(10);
    chk("unmuted runs", rises[2] > r2, 1);
    apll_lock_i <= 1'b1;
    step(40);
    chk("lock restart", start[0] != old, 1);
    chk("lock aligned", start[1], start[0]);
    final_report;
  end
endmodule // osp_ctrl_bench
bind osp_ctrl osp_ctrl_checker #(.NCH(NCH), .NPLL(NPLL), .SELW(SELW)) u_chk (
  .mclk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .align_global_enable_i, .post_divider_align_enable_i,
  .ch_div_align_enable_i, .pulse_divider_align_enable_i, .ch_pll_select_i,
  .ch_bypass_i, .ch_auto_mute_enable_i, .apll_lock_i,
  .zero_delay_feedback_mode_i, .clk_out_o, .ch_valid_o, .pulse_div_reset_o,
  .post_div_reset_o, .align_active_o, .feedback_clk_o, .loop_phase_offset_o);

/* File: verification/osp_ctrl_checker.sv */
// concurrent checks on the output align block ports
`timescale 1ns/1ps
`include "osp_ctrl_map.vh"
module osp_ctrl_checker #(
  parameter NCH  = 4,
  parameter NPLL = 2,
  parameter SELW = 1
) (
  // clock and reset
  input wire                mclk_i,
  input wire                arst_n_i,
  // register port
  input wire [9:0]          reg_addr_i,
  input wire [7:0]          reg_wdata_i,
  input wire                reg_wr_i,
  // configuration
  input wire                align_global_enable_i,
  input wire [NPLL-1:0]     post_divider_align_enable_i,
  input wire [NCH-1:0]      ch_div_align_enable_i,
  input wire [NCH-1:0]      pulse_divider_align_enable_i,
  input wire [NCH*SELW-1:0] ch_pll_select_i,
  input wire [NCH-1:0]      ch_bypass_i,
  input wire [NCH-1:0]      ch_auto_mute_enable_i,
  input wire                apll_lock_i,
  input wire                zero_delay_feedback_mode_i,
  // outputs
  input wire [NCH-1:0]      clk_out_o,
  input wire [NCH-1:0]      ch_valid_o,
  input wire [NCH-1:0]      pulse_div_reset_o,
  input wire [NPLL-1:0]     post_div_reset_o,
  input wire                align_active_o,
  input wire                feedback_clk_o,
  input wire [44:0]         loop_phase_offset_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  wire sw_set = reg_wr_i && reg_addr_i == `OSP_ADDR_SYNC_CONTROL
                && reg_wdata_i[`OSP_SOFTWARE_ALIGN_REQUEST_BIT];
  wire ofs_wr = reg_wr_i && reg_addr_i == `OSP_ADDR_PH_OFS_BYTE0;
  sw_align_a: assert property (sw_set && align_global_enable_i ##1
    align_global_enable_i |=> align_active_o) else $error("align missing");
  gen_off_a: assert property (!align_global_enable_i [*2] |=>
    !align_active_o) else $error("align without global enable");
  post_rst_a: assert property (post_div_reset_o == $past(
    {NPLL{align_active_o}} & post_divider_align_enable_i))
    else $error("post-divider reset wrong");
  offset_load_a: assert property (ofs_wr |=>
    loop_phase_offset_o[7:0] == $past(reg_wdata_i)) else $error("offset");
  offset_keep_a: assert property (!ofs_wr |=>
    $stable(loop_phase_offset_o)) else $error("offset moved");
  zdm_feed_a: assert property (zero_delay_feedback_mode_i |=>
    feedback_clk_o == $past(clk_out_o[0])) else $error("feedback");
  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_ch
      wire [SELW-1:0] sel = ch_pll_select_i[i*SELW +: SELW];
      wire grp = ch_div_align_enable_i[i] && !ch_bypass_i[i]
                 && post_divider_align_enable_i[sel];
      held_low_a: assert property ((align_active_o && grp) [*2] |->
        !clk_out_o[i]) else $error("aligned channel not low");
      src_invalid_a: assert property (post_div_reset_o[sel] [*2] |->
        !ch_valid_o[i]) else $error("channel valid on held source");
      mute_low_a: assert property ((ch_auto_mute_enable_i[i]
        && !apll_lock_i) [*5] |-> !clk_out_o[i] && !ch_valid_o[i])
        else $error("muted channel active");
      // a pulse divider only follows a channel that really joins a group
      pulse_rst_a: assert property (pulse_div_reset_o[i] == $past(
        align_active_o && ch_div_align_enable_i[i]
        && post_divider_align_enable_i[sel]
        && pulse_divider_align_enable_i[i]))
        else $error("pulse divider reset");
    end
  endgenerate
endmodule // osp_ctrl_checker

/* File: verification/osp_ctrl_partner.sv */
// downstream clock receivers: edge counts and restart stamps
`timescale 1ns/1ps
module osp_ctrl_partner #(
  parameter NCH = 4
) (
  // clock and reset
  input  wire           mclk_i,
  input  wire           arst_n_i,
  // received clocks
  input  wire [NCH-1:0] clk_i,
  // observations
  output int            rises_o [NCH],
  output int            start_o [NCH]
);
  int cyc;
  int lows [NCH];
  // a rise after 8 quiet cycles marks a restart; normal low phases are shorter
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cyc <= 0;
      for (int i = 0; i < NCH; i++) begin
        lows[i] <= 0;
        rises_o[i] <= 0;
        start_o[i] <= 0;
      end
    end else begin
      cyc <= cyc + 1;
      for (int i = 0; i < NCH; i++) begin
        lows[i] <= clk_i[i] ? 0 : lows[i] + 1;
        if (clk_i[i] && lows[i] > 0)
          rises_o[i] <= rises_o[i] + 1;
        if (clk_i[i] && lows[i] >= 8)
          start_o[i] <= cyc;
      end
    end
  end
endmodule // osp_ctrl_partner
